//--- rtl/pif_regs.svh
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH

// Data addresses of the registers handled by this block.
`define PIF_ADDR_FLAGS      8'h16
`define PIF_ADDR_ENABLES    8'h17
`define PIF_ADDR_CPU_STATUS 8'h06
`define PIF_BANK_PERIPH     1'h1

// Bit positions shared by the flag and enable registers.
`define PIF_BIT_PIN_CHANGE  7
`define PIF_BIT_TIMER_THREE 6
`define PIF_BIT_TIMER_TWO   5
`define PIF_BIT_TIMER_ONE   4
`define PIF_BIT_CAPTURE_TWO 3
`define PIF_BIT_CAPTURE_ONE 2
`define PIF_BIT_TX_EMPTY    1
`define PIF_BIT_RX_FULL     0

// Software writable flag bits; the two serial flags are read only.
`define PIF_FLAG_WR_MASK    8'hFC

// Bit positions inside the CPU status register.
`define PIF_BIT_STACK_AVAIL 5
`define PIF_BIT_GLOBAL_DIS  4
`define PIF_BIT_WDOG_TMO    3
`define PIF_BIT_SLEEP_ENT   2

// Reset values.
`define PIF_RST_FLAGS       8'h02
`define PIF_RST_ENABLES     8'h00
`define PIF_RST_GLOBAL_DIS  1'h1

// Timer rollover targets.
`define PIF_ZERO_8          8'h00
`define PIF_ZERO_16         16'h0000
`define PIF_FULL_16         16'hFFFF

`endif

//--- rtl/pif_pkg.sv
package pif_pkg;

   typedef logic [7:0]  pif_byte_t;
   typedef logic [15:0] pif_word_t;

   typedef struct packed {
      pif_byte_t flags;
      pif_byte_t enables;
      logic      global_dis;
      pif_byte_t rdata;
      logic      req;
      logic      core_req;
      logic      wake_cond;
      logic      wake_vec;
      pif_byte_t port_s1;
      pif_byte_t port_s2;
      pif_byte_t port_latch;
      logic [1:0] cap_s1;
      logic [1:0] cap_s2;
      logic [1:0] cap_s3;
      logic      master_clear_pin_s1;
      logic      master_clear_pin_s2;
      pif_byte_t t1_prev;
      pif_byte_t t2_prev;
      pif_word_t t3_prev;
   } pif_state_t;

endpackage : pif_pkg

//--- rtl/pif_irq_top.sv
// Behaviour
// - Enable bits ordered pin change down to receive.
// - Enable one permits, zero blocks that source.
// - Enable register at 17h bank one, resets zero.
// - Flag register at 16h bank one, resets 02h.
// - Flags set regardless of enables or global disable.
// - Pin change flag follows pins versus latched value.
// - Capture mode one: timer three overflow sets flag.
// - Capture mode zero: period rollover sets flag.
// - Timer two period rollover sets its flag.
// - Narrow mode: timer one rollover sets flag.
// - Wide mode: paired rollover sets timer one flag.
// - Capture two pin event sets its flag.
// - Capture one pin event sets its flag.
// - Transmit flag mirrors transmit buffer empty.
// - Receive flag mirrors receive buffer full.
// - Sleep wake-up keeps flags and enables intact.
// - Wake with disable clear loads interrupt vector.
// - Status watchdog, sleep, stack bits ignore writes.
`include "pif_regs.svh"

module pif_irq_top
   import pif_pkg::*;
(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        wdog_reset,
   input  wire logic        master_clear_pin_n,
   // Register port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_bank,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Port pins and capture inputs.
   input  wire logic [7:0]  port_b_pins,
   input  wire logic        port_b_read,
   input  wire logic        capture_one_pin,
   input  wire logic        capture_two_pin,
   // Timers and their modes.
   input  wire logic [7:0]  timer_one_count,
   input  wire logic [7:0]  timer_two_count,
   input  wire logic [15:0] timer_three_count,
   input  wire logic [7:0]  timer_one_period,
   input  wire logic [7:0]  timer_two_period,
   input  wire logic [15:0] timer_three_period,
   input  wire logic        capture_one_mode_sel,
   input  wire logic        timer_pair_wide_mode,
   // Serial buffer levels.
   input  wire logic        tx_buf_empty,
   input  wire logic        rx_buf_full,
   // Core status.
   input  wire logic        core_sleeping,
   input  wire logic        stack_avail_flag,
   input  wire logic        watchdog_timeout_flag,
   input  wire logic        sleep_entered_flag,
   // Requests to the core.
   output logic             periph_irq_req,
   output logic             core_irq_req,
   output logic             global_irq_disable,
   output logic             wake_vector_load
);

   logic       rst_s1;
   logic       rst_s2;
   pif_state_t st_reg;
   pif_state_t st_next;
   pif_byte_t  ev;
   logic       soft_rst;
   logic       wr_flags;
   logic       wr_en;
   logic       wr_cpu;
   logic       t1_roll_n;
   logic       t1_roll_w;
   logic       t3_roll_p;
   logic       t3_ovf;
   logic       pending;
   logic       wake_now;

   // Reset release through two flip-flops.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1 <= 1'h0;
         rst_s2 <= 1'h0;
      end else begin
         rst_s1 <= 1'h1;
         rst_s2 <= rst_s1;
      end
   end

   assign soft_rst = wdog_reset | ~st_reg.master_clear_pin_s2;
   assign wr_flags = reg_wr && reg_bank == `PIF_BANK_PERIPH
                     && reg_addr == `PIF_ADDR_FLAGS;
   assign wr_en    = reg_wr && reg_bank == `PIF_BANK_PERIPH
                     && reg_addr == `PIF_ADDR_ENABLES;
   assign wr_cpu   = reg_wr && reg_addr == `PIF_ADDR_CPU_STATUS;

   // Timer rollover detection from successive counts.
   assign t1_roll_n = st_reg.t1_prev == timer_one_period
                      && timer_one_count == `PIF_ZERO_8;
   assign t1_roll_w = {st_reg.t2_prev, st_reg.t1_prev}
                      == {timer_two_period, timer_one_period}
                      && {timer_two_count, timer_one_count}
                      == `PIF_ZERO_16;
   assign t3_roll_p = st_reg.t3_prev == timer_three_period
                      && timer_three_count == `PIF_ZERO_16;
   assign t3_ovf    = st_reg.t3_prev == `PIF_FULL_16
                      && timer_three_count == `PIF_ZERO_16;

   // Event vector, independent of enables and global disable.
   always_comb begin
      ev = 8'h00;
      ev[`PIF_BIT_PIN_CHANGE]  = st_reg.port_s2 != st_reg.port_latch;
      ev[`PIF_BIT_TIMER_THREE] = capture_one_mode_sel ? t3_ovf
                                                      : t3_roll_p;
      ev[`PIF_BIT_TIMER_TWO]   = st_reg.t2_prev == timer_two_period
                                 && timer_two_count == `PIF_ZERO_8;
      ev[`PIF_BIT_TIMER_ONE]   = timer_pair_wide_mode ? t1_roll_w
                                                      : t1_roll_n;
      ev[`PIF_BIT_CAPTURE_TWO] = st_reg.cap_s2[1] & ~st_reg.cap_s3[1];
      ev[`PIF_BIT_CAPTURE_ONE] = st_reg.cap_s2[0] & ~st_reg.cap_s3[0];
   end

   assign pending  = |(st_reg.flags & st_reg.enables);
   assign wake_now = core_sleeping & pending & ~st_reg.global_dis;

   always_comb begin
      st_next = st_reg;
      // Synchronisers and history.
      st_next.port_s1 = port_b_pins;
      st_next.port_s2 = st_reg.port_s1;
      st_next.cap_s1  = {capture_two_pin, capture_one_pin};
      st_next.cap_s2  = st_reg.cap_s1;
      st_next.cap_s3  = st_reg.cap_s2;
      st_next.master_clear_pin_s1 = master_clear_pin_n;
      st_next.master_clear_pin_s2 = st_reg.master_clear_pin_s1;
      st_next.t1_prev = timer_one_count;
      st_next.t2_prev = timer_two_count;
      st_next.t3_prev = timer_three_count;
      // Reading the port ends the mismatch.
      if (port_b_read) begin
         st_next.port_latch = st_reg.port_s2;
      end
      // Register writes; events then win over a clearing write.
      if (wr_flags) begin
         st_next.flags = (reg_wdata & `PIF_FLAG_WR_MASK)
                         | (st_reg.flags & ~`PIF_FLAG_WR_MASK);
      end
      if (wr_en) begin
         st_next.enables = reg_wdata;
      end
      if (wr_cpu) begin
         st_next.global_dis = reg_wdata[`PIF_BIT_GLOBAL_DIS];
      end
      st_next.flags = st_next.flags | ev;
      st_next.flags[`PIF_BIT_TX_EMPTY] = tx_buf_empty;
      st_next.flags[`PIF_BIT_RX_FULL]  = rx_buf_full;
      // Read data, valid only in the cycle after the strobe.
      st_next.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == `PIF_ADDR_CPU_STATUS) begin
            st_next.rdata[`PIF_BIT_STACK_AVAIL] = stack_avail_flag;
            st_next.rdata[`PIF_BIT_GLOBAL_DIS]  = st_reg.global_dis;
            st_next.rdata[`PIF_BIT_WDOG_TMO]    = watchdog_timeout_flag;
            st_next.rdata[`PIF_BIT_SLEEP_ENT]   = sleep_entered_flag;
         end else if (reg_bank == `PIF_BANK_PERIPH
                      && reg_addr == `PIF_ADDR_FLAGS) begin
            st_next.rdata = st_reg.flags;
         end else if (reg_bank == `PIF_BANK_PERIPH
                      && reg_addr == `PIF_ADDR_ENABLES) begin
            st_next.rdata = st_reg.enables;
         end
      end
      // Requests to the core.
      st_next.req       = pending;
      st_next.core_req  = pending & ~st_reg.global_dis;
      st_next.wake_cond = wake_now;
      st_next.wake_vec  = wake_now & ~st_reg.wake_cond;
      // Master clear and watchdog reset return flags, enables, global disable and requests to reset values.
      if (soft_rst) begin
         st_next.flags      = `PIF_RST_FLAGS;
         st_next.enables    = `PIF_RST_ENABLES;
         st_next.global_dis = `PIF_RST_GLOBAL_DIS;
         st_next.port_latch = st_reg.port_s2;
         st_next.req        = 1'h0;
         st_next.core_req   = 1'h0;
         st_next.wake_cond  = 1'h0;
         st_next.wake_vec   = 1'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         st_reg            <= '0;
         st_reg.flags      <= `PIF_RST_FLAGS;
         st_reg.enables    <= `PIF_RST_ENABLES;
         st_reg.global_dis <= `PIF_RST_GLOBAL_DIS;
         st_reg.master_clear_pin_s1    <= 1'h1;
         st_reg.master_clear_pin_s2    <= 1'h1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata          = st_reg.rdata;
   assign periph_irq_req     = st_reg.req;
   assign core_irq_req       = st_reg.core_req;
   assign global_irq_disable = st_reg.global_dis;
   assign wake_vector_load   = st_reg.wake_vec;

   // Checks.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_s2);

   enable_write_a: assert property (
      (wr_en && !soft_rst) |=> st_reg.enables == $past(reg_wdata))
      else $error("Enable register did not take the write.");

   request_mask_a: assert property (
      !soft_rst |=> periph_irq_req
                    == |($past(st_reg.flags) & $past(st_reg.enables)))
      else $error("Peripheral request does not match flags and enables.");

   event_sets_a: assert property (
      (ev[`PIF_BIT_TIMER_TWO] && !soft_rst)
      |=> st_reg.flags[`PIF_BIT_TIMER_TWO])
      else $error("Timer two event lost.");

   pin_change_a: assert property (
      (st_reg.port_s2 != st_reg.port_latch && !soft_rst)
      |=> st_reg.flags[`PIF_BIT_PIN_CHANGE])
      else $error("Pin change flag not set on mismatch.");

   capture_edge_a: assert property (
      ($rose(st_reg.cap_s2[0]) && !soft_rst)
      |=> st_reg.flags[`PIF_BIT_CAPTURE_ONE])
      else $error("Capture one event did not set its flag.");

   tx_mirror_a: assert property (
      !soft_rst |=> st_reg.flags[`PIF_BIT_TX_EMPTY] == $past(tx_buf_empty))
      else $error("Transmit flag does not follow buffer state.");

   wake_vector_a: assert property (
      wake_vector_load |-> $past(core_sleeping) && !$past(st_reg.global_dis)
                           && $past(pending))
      else $error("Vector load without enabled wake condition.");

   read_timing_a: assert property (
      (reg_rd && reg_bank && reg_addr == `PIF_ADDR_FLAGS)
      |=> reg_rdata == $past(st_reg.flags) ##1 reg_rdata == 8'h00
          || $past(reg_rd))
      else $error("Flag read data wrong or held too long.");

   core_gate_a: assert property (
      core_irq_req |-> $past(pending) && !$past(st_reg.global_dis))
      else $error("Core request raised while globally disabled.");

   cover_wake_c:    cover property (wake_vector_load);
   cover_wide_c:    cover property (timer_pair_wide_mode && t1_roll_w);
   cover_t3_ovf_c:  cover property (capture_one_mode_sel && t3_ovf);
   cover_set_win_c: cover property (wr_flags && |(ev & reg_wdata ^ ev));

endmodule : pif_irq_top

//--- testbench/pif_timer_model.sv
module pif_timer_model (
   // Clock and run control.
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic [7:0] period,
   // Timer value seen by the block.
   output logic      [7:0] count
);
   timeunit 1ns;
   timeprecision 100ps;
   // Counts up while running and rolls to zero after matching the period.
   always_ff @(posedge ref_clk) begin
      if (!run) begin
         count <= 8'h00;
      end else if (count == period) begin
         count <= 8'h00;
      end else begin
         count <= count + 8'h01;
      end
   end
endmodule : pif_timer_model

//--- testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk = 1'b0, rstn = 1'b0, wdog = 1'b0, rd = 1'b0;
   logic        wr = 1'b0, pb_rd = 1'b0, cap1 = 1'b0, cap2 = 1'b0;
   logic        wide = 1'b0, sel3 = 1'b0, tx = 1'b1, rx = 1'b0;
   logic        slp = 1'b0, run = 1'b0, bank = 1'b1, mclrn = 1'b1;
   logic        stk = 1'b0, wdt = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, pins = 8'h00;
   logic [7:0]  t1c = 8'h00, t2c = 8'h00, t2m, rdata;
   logic [15:0] t3c = 16'h0000;
   logic        preq, creq, gdis, wake;
   int          fails = 0, samples_checked = 0, cyc = 0, wakes = 0;
   logic [23:0] rows [5] = '{24'h17A5A5, 24'h175A5A, 24'h16FCFC,
                             24'h160000, 24'h20FF00};
   logic [7:0]  texp [4] = '{8'h10, 8'h30, 8'h40, 8'h40};

   pif_timer_model pif_timer_model_inst (.ref_clk(ref_clk), .run(run),
      .period(8'h07), .count(t2m));

   pif_irq_top pif_irq_top_inst (.ref_clk(ref_clk), .rstn(rstn),
      .wdog_reset(wdog), .master_clear_pin_n(mclrn), .reg_addr(addr),
      .reg_bank(bank), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .port_b_pins(pins), .port_b_read(pb_rd),
      .capture_one_pin(cap1), .capture_two_pin(cap2),
      .timer_one_count(t1c), .timer_two_count(run ? t2m : t2c),
      .timer_three_count(t3c), .timer_one_period(8'h05),
      .timer_two_period(8'h07), .timer_three_period(16'h0123),
      .capture_one_mode_sel(sel3), .timer_pair_wide_mode(wide),
      .tx_buf_empty(tx), .rx_buf_full(rx), .core_sleeping(slp),
      .stack_avail_flag(stk), .watchdog_timeout_flag(wdt),
      .sleep_entered_flag(1'b0), .periph_irq_req(preq),
      .core_irq_req(creq), .global_irq_disable(gdis),
      .wake_vector_load(wake));

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (wake === 1'b1) wakes++;
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end

   task print_verdict;
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // Lets pending events land, then reads and compares the masked byte.
   task rd_chk(input logic [7:0] a, input logic [7:0] m,
               input logic [7:0] e);
      repeat (6) @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      @(negedge ref_clk);
      chk(rdata & m, e);
   endtask : rd_chk

   initial begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd_chk(8'h16, 8'hFF, 8'h02);
      rd_chk(8'h17, 8'hFF, 8'h00);
      chk({7'h00, gdis}, 8'h01);
      tx <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wr_reg(rows[i][23:16], rows[i][15:8]);
         rd_chk(rows[i][23:16], 8'hFF, rows[i][7:0]);
      end
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h16, 8'h00);
         wide <= (i == 1);
         sel3 <= (i == 3);
         t1c  <= (i < 2) ? 8'h05 : 8'h00;
         t2c  <= (i == 1) ? 8'h07 : 8'h00;
         t3c  <= (i == 3) ? 16'hFFFF : (i == 2) ? 16'h0123 : 16'h0000;
         repeat (2) @(posedge ref_clk);
         t1c  <= 8'h00;
         t2c  <= 8'h00;
         t3c  <= 16'h0000;
         rd_chk(8'h16, 8'hF0, texp[i]);
      end
      wr_reg(8'h16, 8'h00);
      run <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd_chk(8'h16, 8'hFF, 8'h20);
      run <= 1'b0;
      chk({7'h00, preq}, 8'h00);
      wr_reg(8'h17, 8'h20);
      rd_chk(8'h17, 8'hFF, 8'h20);
      chk({6'h00, preq, creq}, 8'h02);
      wr_reg(8'h17, 8'h00);
      wr_reg(8'h06, 8'hFF);
      rd_chk(8'h06, 8'h2C, 8'h00);
      stk <= 1'b1;
      wdt <= 1'b1;
      rd_chk(8'h06, 8'h2C, 8'h28);
      stk <= 1'b0;
      wdt <= 1'b0;
      wr_reg(8'h06, 8'h00);
      slp <= 1'b1;
      wr_reg(8'h17, 8'h20);
      rd_chk(8'h17, 8'hFF, 8'h20);
      chk({6'h00, preq, creq}, 8'h03);
      chk(wakes[7:0], 8'h01);
      slp <= 1'b0;
      rd_chk(8'h16, 8'hFF, 8'h20);
      wr_reg(8'h16, 8'h00);
      cap1 <= 1'b1;
      rd_chk(8'h16, 8'h0C, 8'h04);
      cap2 <= 1'b1;
      rd_chk(8'h16, 8'h0C, 8'h0C);
      pins <= 8'h41;
      rd_chk(8'h16, 8'h80, 8'h80);
      wr_reg(8'h16, 8'h00);
      rd_chk(8'h16, 8'h80, 8'h80);
      @(posedge ref_clk);
      pb_rd <= 1'b1;
      @(posedge ref_clk);
      pb_rd <= 1'b0;
      wr_reg(8'h16, 8'h00);
      rd_chk(8'h16, 8'h80, 8'h00);
      rx <= 1'b1;
      rd_chk(8'h16, 8'h03, 8'h01);
      tx <= 1'b1;
      rx <= 1'b0;
      rd_chk(8'h16, 8'h03, 8'h02);
      wr_reg(8'h16, 8'hFC);
      wdog <= 1'b1;
      @(posedge ref_clk);
      wdog <= 1'b0;
      rd_chk(8'h16, 8'hFF, 8'h02);
      rd_chk(8'h17, 8'hFF, 8'h00);
      chk({7'h00, gdis}, 8'h01);
      bank <= 1'b0;
      wr_reg(8'h17, 8'hFF);
      @(posedge ref_clk);
      bank <= 1'b1;
      rd_chk(8'h17, 8'hFF, 8'h00);
      wr_reg(8'h17, 8'hFF);
      mclrn <= 1'b0;
      repeat (4) @(posedge ref_clk);
      mclrn <= 1'b1;
      rd_chk(8'h17, 8'hFF, 8'h00);
      print_verdict();
   end
endmodule : testbench
